// >>> rtl/usf_flags.v
// Purpose: USB OTG line and session status plus device event flags
// Assumes: All inputs synchronous to ref_clk; event inputs are pulses
// Notes: Word-wide register port, read data one cycle after the strobe
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.

// Register map
// Word 0: line and session status, read only
// Word 1: event flags, write one to clear
// Word 2: interrupt mask, same layout as word 1
// Word 3: error enable, one bit per error source
// Word 4: error status, write one to clear
// Word 5: head of the transfer status queue, read only
// Other words read as zero and ignore writes

// Register port timing
// Write acts at the edge that samples the write strobe
// Read data stand for one cycle after the read strobe
// Read data return to zero when no read is pending
// No wait states, so back-to-back strobes are fine

// Status word
// Comparator and pin levels are registered once
// One cycle of lag, traded for a clean timing path
// Nothing on the write side can reach these bits
// Line stability restarts on any change of SE0 or J

// Event flags
// Each flag is sticky until software clears it
// A set in the clearing cycle wins over the clear
// Software should write whole words with ones only where meant
// A read-modify-write clears every set flag except the error summary, and the token flag while more words are queued
// Upper byte and unused positions are forced to zero

// Error summary
// Built live from error status and error enable
// Not stored, so writes to the flag word cannot clear it
// Software clears it through error status or enable

// Timed line detectors
// Bus reset on SE0, resume on K, idle on J
// Each fires once, then waits for its condition to end
// Counters saturate, so a long episode cannot wrap
// K and J swap with the speed input

// Transfer status queue
// Four words deep, head word held in a register
// Clearing the token flag pops the head
// With more words queued the flag stays up
// A token while full, with no pop in that cycle, is dropped but still flags
// Engine should watch the ready output to avoid loss

// Interrupt
// Level output, high while any unmasked flag is set
// Status word changes never raise it

// Limitations
// Inputs are taken as synchronous; no synchroniser here
// Timer lengths assume the 20 ns clock period
// Shorter stable and idle counts suit simulation only
// Event inputs are single-cycle pulses
`timescale 1ns/100ps
`include "usf_regs.vh"

module usf_flags #(
    parameter STABLE_CYC = `USF_STABLE_CYC,
    parameter IDLE_CYC = `USF_IDLE_CYC
) (
    input wire ref_clk,
    input wire rst_b,
    // Register port
    input wire [2:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata_reg,
    output wire irq,
    // Bus lines and comparators
    input wire dp_in,
    input wire dm_in,
    input wire low_speed,
    input wire cable_id_in,
    input wire sess_valid_in,
    input wire sess_end_in,
    input wire supply_valid_in,
    // Transaction engine events
    input wire stall_sent,
    input wire token_done,
    input wire [7:0] token_status,
    input wire sof_received,
    input wire sof_threshold,
    input wire [7:0] error_events,
    output wire token_ready
);
    localparam [17:0] K_HOLD = `USF_K_HOLD_CYC;
    localparam [17:0] RST_HOLD = `USF_RST_HOLD_CYC;
    localparam [17:0] STABLE_LIM = STABLE_CYC;
    localparam [17:0] IDLE_LIM = IDLE_CYC;

    // Line decode
    wire se0;
    wire j_state;
    wire k_state;
    wire [1:0] line_code;
    reg [1:0] line_prev_reg;
    reg [17:0] stable_cnt_reg;
    reg line_stable_reg;

    // Status samples
    reg cable_id_reg;
    reg sess_valid_reg;
    reg sess_end_reg;
    reg supply_valid_reg;
    wire [15:0] otg_status;

    // Flag and control registers
    reg [15:0] evt_flags_reg;
    reg [15:0] evt_flags_next;
    reg [15:0] evt_mask_reg;
    reg [7:0] err_enable_reg;
    reg [7:0] err_stat_reg;
    wire [15:0] evt_view;
    wire [15:0] clr_bits;
    wire err_summary;

    // Timed line detectors: 0 bus reset, 1 resume, 2 idle
    wire [2:0] det_cond;
    wire [2:0] det_fire;

    // Transfer status queue
    wire [7:0] xfer_head;
    wire [2:0] xfer_count;
    wire xfer_full;
    wire token_pop;

    // Line state from the pair; J and K swap with speed
    assign se0 = !dp_in && !dm_in;
    assign j_state = low_speed ? (!dp_in && dm_in) : (dp_in && !dm_in);
    assign k_state = low_speed ? (dp_in && !dm_in) : (!dp_in && dm_in);
    assign line_code = {se0, j_state};

    // Line stability: any change of SE0 or J restarts the 1 ms window
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            line_prev_reg <= 2'h0;
            stable_cnt_reg <= 18'h0;
            line_stable_reg <= 1'b0;
        end else begin
            line_prev_reg <= line_code;
            if (line_code != line_prev_reg) begin
                stable_cnt_reg <= 18'h0;
                line_stable_reg <= 1'b0;
            end else if (stable_cnt_reg < STABLE_LIM - 18'h1) begin
                stable_cnt_reg <= stable_cnt_reg + 18'h1;
            end else begin
                line_stable_reg <= 1'b1;
            end
        end
    end

    // Comparator and pin levels, sampled; software has no path here
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cable_id_reg <= 1'b0;
            sess_valid_reg <= 1'b0;
            sess_end_reg <= 1'b0;
            supply_valid_reg <= 1'b0;
        end else begin
            cable_id_reg <= cable_id_in;
            sess_valid_reg <= sess_valid_in;
            sess_end_reg <= sess_end_in;
            supply_valid_reg <= supply_valid_in;
        end
    end

    // Status word; unused bits tie to zero
    assign otg_status = {8'h00,
                         cable_id_reg,
                         1'b0,
                         line_stable_reg,
                         1'b0,
                         sess_valid_reg,
                         sess_end_reg,
                         1'b0,
                         supply_valid_reg};

    assign det_cond = {j_state, k_state, se0};

    // One firing per episode; the condition must drop before rearming
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_det
            localparam [17:0] LIM = (gi == 2) ? IDLE_LIM : ((gi == 1) ? K_HOLD : RST_HOLD);
            reg [17:0] cnt_reg;
            reg done_reg;
            always @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    cnt_reg <= 18'h0;
                    done_reg <= 1'b0;
                end else if (!det_cond[gi]) begin
                    cnt_reg <= 18'h0;
                    done_reg <= 1'b0;
                end else if (!done_reg) begin
                    if (cnt_reg >= LIM - 18'h1) begin
                        done_reg <= 1'b1;
                    end else begin
                        cnt_reg <= cnt_reg + 18'h1;
                    end
                end
            end
            assign det_fire[gi] = det_cond[gi] && !done_reg && (cnt_reg >= LIM - 18'h1);
        end
    endgenerate

    // Whole-word write to the flag register clears where a one is written
    assign clr_bits = (reg_wr && reg_addr == `USF_OFF_EVT_FLAGS) ?
                      (reg_wdata & `USF_W1C_MASK) : 16'h0000;
    assign token_pop = clr_bits[`USF_B_TOKEN] && evt_flags_reg[`USF_B_TOKEN];

    // Sticky flags; a set in the clearing cycle wins
    always @* begin
        evt_flags_next = evt_flags_reg & ~clr_bits;
        if (stall_sent) begin
            evt_flags_next[`USF_B_STALL] = 1'b1;
        end
        if (det_fire[1]) begin
            evt_flags_next[`USF_B_RESUME] = 1'b1;
        end
        if (det_fire[2]) begin
            evt_flags_next[`USF_B_IDLE] = 1'b1;
        end
        // Next queued token keeps the flag up after an advance
        if (token_done || (token_pop && xfer_count > 3'h1)) begin
            evt_flags_next[`USF_B_TOKEN] = 1'b1;
        end
        if (sof_received || sof_threshold) begin
            evt_flags_next[`USF_B_SOF] = 1'b1;
        end
        if (det_fire[0]) begin
            evt_flags_next[`USF_B_BUS_RST] = 1'b1;
        end
        evt_flags_next = evt_flags_next & `USF_W1C_MASK;
    end

    // Flag register, zero at reset, set only by the events above
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            evt_flags_reg <= `USF_RST_REG16;
        end else begin
            evt_flags_reg <= evt_flags_next;
        end
    end

    // Error sources latch; summary is gated by the enable register
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            err_stat_reg <= `USF_RST_REG8;
        end else if (reg_wr && reg_addr == `USF_OFF_ERR_STAT) begin
            err_stat_reg <= (err_stat_reg & ~reg_wdata[7:0]) | error_events;
        end else begin
            err_stat_reg <= err_stat_reg | error_events;
        end
    end
    assign err_summary = |(err_stat_reg & err_enable_reg);

    // Summary bit is not stored, so flag writes cannot touch it
    assign evt_view = evt_flags_reg | ({15'h0, err_summary} << `USF_B_ERR);

    // Writable control registers
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            evt_mask_reg <= `USF_RST_REG16;
            err_enable_reg <= `USF_RST_REG8;
        end else if (reg_wr) begin
            if (reg_addr == `USF_OFF_EVT_MASK) begin
                evt_mask_reg <= reg_wdata & 16'h00ff;
            end
            if (reg_addr == `USF_OFF_ERR_ENABLE) begin
                err_enable_reg <= reg_wdata[7:0];
            end
        end
    end

    // Level interrupt from any unmasked flag
    assign irq = |(evt_view & evt_mask_reg);

    // Read data one cycle after the strobe, zero otherwise or unmapped
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_reg <= `USF_RST_REG16;
        end else if (reg_rd) begin
            case (reg_addr)
                `USF_OFF_OTG_STAT: reg_rdata_reg <= otg_status;
                `USF_OFF_EVT_FLAGS: reg_rdata_reg <= evt_view;
                `USF_OFF_EVT_MASK: reg_rdata_reg <= evt_mask_reg;
                `USF_OFF_ERR_ENABLE: reg_rdata_reg <= {8'h00, err_enable_reg};
                `USF_OFF_ERR_STAT: reg_rdata_reg <= {8'h00, err_stat_reg};
                `USF_OFF_XFER_STAT: reg_rdata_reg <= {8'h00, xfer_head};
                default: reg_rdata_reg <= 16'h0000;
            endcase
        end else begin
            reg_rdata_reg <= 16'h0000;
        end
    end

    // Ready drops while the queue is full; a status word pushed then is lost unless the head pops in the same cycle
    assign token_ready = !xfer_full;

    usf_stat_fifo u_xfer_fifo (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .push(token_done),
        .push_data(token_status),
        .pop(token_pop),
        .head_reg(xfer_head),
        .count(xfer_count),
        .full(xfer_full)
    );
endmodule

// >>> rtl/usf_regs.vh
// Purpose: Constants for the USB status and event flag block
// Assumes: 50 MHz controller clock, 3-bit word address on the register port
// Notes: Offsets are word indices; data are 16 bits wide
`ifndef USF_REGS_VH
`define USF_REGS_VH

// Register offsets
`define USF_OFF_OTG_STAT 3'h0
`define USF_OFF_EVT_FLAGS 3'h1
`define USF_OFF_EVT_MASK 3'h2
`define USF_OFF_ERR_ENABLE 3'h3
`define USF_OFF_ERR_STAT 3'h4
`define USF_OFF_XFER_STAT 3'h5

// Line and session status bit positions
`define USF_B_CABLE_ID 7
`define USF_B_LINE_STABLE 5
`define USF_B_SESS_VALID 3
`define USF_B_SESS_END 2
`define USF_B_SUPPLY_VALID 0

// Event flag bit positions
`define USF_B_STALL 7
`define USF_B_RESUME 5
`define USF_B_IDLE 4
`define USF_B_TOKEN 3
`define USF_B_SOF 2
`define USF_B_ERR 1
`define USF_B_BUS_RST 0

// Flags that software clears by writing one
`define USF_W1C_MASK 16'h00bd

// Reset values
`define USF_RST_REG16 16'h0000
`define USF_RST_REG8 8'h00

// Timing
`define USF_CLK_NS 20
`define USF_K_HOLD_NS 2500
`define USF_RST_HOLD_NS 2500
`define USF_STABLE_US 1000
`define USF_IDLE_US 3000
`define USF_K_HOLD_CYC ((`USF_K_HOLD_NS + `USF_CLK_NS - 1) / `USF_CLK_NS)
`define USF_RST_HOLD_CYC ((`USF_RST_HOLD_NS + `USF_CLK_NS - 1) / `USF_CLK_NS)
`define USF_STABLE_CYC (`USF_STABLE_US * 1000 / `USF_CLK_NS)
`define USF_IDLE_CYC (`USF_IDLE_US * 1000 / `USF_CLK_NS)

// Transfer status queue
`define USF_XFER_DEPTH 4
`define USF_XFER_AW 2

`endif

// >>> rtl/usf_stat_fifo.v
// Purpose: Queue of transfer status words behind the token flag
// Assumes: Push and pop are one-cycle pulses from the flag block
// Notes: Head word comes out of a register; push when full is dropped unless a pop comes in the same cycle
`timescale 1ns/100ps
`include "usf_regs.vh"

module usf_stat_fifo (
    input wire ref_clk,
    input wire rst_b,
    input wire push,
    input wire [7:0] push_data,
    input wire pop,
    output reg [7:0] head_reg,
    output wire [2:0] count,
    output wire full
);
    reg [7:0] mem [0:`USF_XFER_DEPTH-1];
    reg [`USF_XFER_AW-1:0] wr_ptr_reg;
    reg [`USF_XFER_AW-1:0] rd_ptr_reg;
    reg [2:0] count_reg;
    wire do_push;
    wire do_pop;
    wire [`USF_XFER_AW-1:0] rd_ptr_inc;

    assign full = (count_reg == `USF_XFER_DEPTH);
    assign count = count_reg;
    assign do_pop = pop && (count_reg != 3'h0);
    assign do_push = push && (!full || do_pop);
    assign rd_ptr_inc = rd_ptr_reg + 1'b1;

    // Storage array, written without reset
    always @(posedge ref_clk) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= push_data;
        end
    end

    // Pointers, count and registered head
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_reg <= {`USF_XFER_AW{1'b0}};
            rd_ptr_reg <= {`USF_XFER_AW{1'b0}};
            count_reg <= 3'h0;
            head_reg <= `USF_RST_REG8;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_reg <= rd_ptr_inc;
            end
            count_reg <= count_reg + {2'h0, do_push} - {2'h0, do_pop};
            // Head follows the next entry; an empty queue shows the new word
            if (do_pop && count_reg > 3'h1) begin
                head_reg <= mem[rd_ptr_inc];
            end else if (do_push && (count_reg == 3'h0 || (do_pop && count_reg == 3'h1))) begin
                head_reg <= push_data;
            end else if (do_pop) begin
                head_reg <= `USF_RST_REG8;
            end
        end
    end
endmodule

// >>> verification/test_usf_flags.sv
// Purpose: Self-checking bench for the USB status and event flag block
// Assumes: Short stable and idle counts keep the run brief
// Notes: Resume and bus reset timers are probed a few cycles either side of 125, idle around IDL
`timescale 1ns/100ps
module test_usf_flags;
    localparam STB = 20;
    localparam IDL = 40;
    localparam logic [15:0] EVB [4] = '{16'h0080, 16'h0008, 16'h0004, 16'h0004};
    logic ref_clk = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, low_speed = 1'h0;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata_reg, d, m;
    logic [3:0] ev = 4'h0, cmpin = 4'h0;
    logic [1:0] line = 2'h0;
    logic [7:0] tstat = 8'h00, errs = 8'h00;
    logic irq, token_ready, dp, dm;
    logic [7:0] q[$];
    int failures = 0, n_checks = 0, k;
    usf_flags #(.STABLE_CYC(STB), .IDLE_CYC(IDL)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_reg(reg_rdata_reg), .irq(irq), .dp_in(dp), .dm_in(dm),
        .low_speed(low_speed), .cable_id_in(cmpin[3]), .sess_valid_in(cmpin[2]),
        .sess_end_in(cmpin[1]), .supply_valid_in(cmpin[0]), .stall_sent(ev[0]),
        .token_done(ev[1]), .token_status(tstat), .sof_received(ev[2]),
        .sof_threshold(ev[3]), .error_events(errs), .token_ready(token_ready));
    usf_bus_peer peer (.low_speed(low_speed), .line(line), .dp(dp), .dm(dm));
    function automatic logic [15:0] stat_exp(logic [3:0] c, logic s);
        return {8'h00, c[3], 1'h0, s, 1'h0, c[2], c[1], 1'h0, c[0]};
    endfunction
    task automatic cmp(logic [15:0] g, logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Bus tasks are entered just after a rising edge
    task automatic wr(logic [2:0] a, logic [15:0] v);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask
    // Strobe held n edges gives n back-to-back reads
    task automatic rd(logic [2:0] a, int n, output logic [15:0] v);
        reg_rd <= 1'h1;
        reg_addr <= a;
        repeat (n) @(posedge ref_clk);
        reg_rd <= 1'h0;
        @(negedge ref_clk);
        v = reg_rdata_reg;
        @(posedge ref_clk);
    endtask
    task automatic rc(logic [2:0] a, logic [15:0] e);
        rd(a, 1, d);
        cmp(d, e);
    endtask
    task automatic cflag(logic [15:0] b, logic [15:0] e);
        rd(3'h1, 1, d);
        cmp(d & b, e);
    endtask
    // Combinational outputs are sampled mid-cycle
    task automatic cbit(int s, logic e);
        @(negedge ref_clk);
        cmp({15'h0000, s ? token_ready : irq}, {15'h0000, e});
        @(posedge ref_clk);
    endtask
    task automatic pulse(int i);
        ev[i] <= 1'h1;
        @(posedge ref_clk);
        ev[i] <= 1'h0;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Clock
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    // Watchdog against a hung run
    initial begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        summarize();
    end
    // Main sequence
    initial begin
        void'($urandom(32'hce836077));
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'h1;
        @(posedge ref_clk);
        cbit(1, 1'h1);
        for (int a = 1; a < 8; a++) rc(a[2:0], 16'h0000);
        $display("end reset test");
        // Comparator levels, write attempts ignored
        repeat (STB) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            cmpin <= 4'($urandom());
            wr(3'h0, 16'hffff);
            @(posedge ref_clk);
            rc(3'h0, stat_exp(cmpin, 1'h1));
        end
        // Short glitch drops the stable bit until the count runs out
        line <= 2'h2;
        repeat (3) @(posedge ref_clk);
        line <= 2'h0;
        repeat (3) @(posedge ref_clk);
        rc(3'h0, stat_exp(cmpin, 1'h0));
        repeat (STB) @(posedge ref_clk);
        rc(3'h0, stat_exp(cmpin, 1'h1));
        $display("end status test");
        // Token bit is never written as one while the queue may be empty
        wr(3'h1, 16'h00b5);
        @(posedge ref_clk);
        for (int i = 0; i < 4; i++) begin
            m = EVB[i];
            tstat <= 8'($urandom());
            wr(3'h2, m);
            pulse(i);
            rd(3'h1, 2, d);
            cmp(d & m, m);
            cbit(0, 1'h1);
            if (i == 1) rc(3'h5, {8'h00, tstat});
            wr(3'h1, 16'h00b5 & ~m);
            cflag(m, m);
            wr(3'h1, m);
            cflag(m, 16'h0000);
            cbit(0, 1'h0);
        end
        $display("end event test");
        // Queue fills at four, fifth word dropped, pops on each clear
        for (int i = 0; i < 5; i++) begin
            tstat <= 8'($urandom());
            pulse(1);
            if (i < 4) q.push_back(tstat);
            cbit(1, i < 3);
        end
        for (int i = 0; i < 4; i++) begin
            rc(3'h5, {8'h00, q.pop_front()});
            cflag(16'h0008, 16'h0008);
            wr(3'h1, 16'h0008);
        end
        cflag(16'h0008, 16'h0000);
        cbit(1, 1'h1);
        $display("end queue test");
        // Resume at both speeds
        for (int s = 0; s < 2; s++) begin
            low_speed <= s[0];
            wr(3'h1, 16'h00b5);
            line <= 2'h1;
            repeat (118) @(posedge ref_clk);
            cflag(16'h0020, 16'h0000);
            repeat (8) @(posedge ref_clk);
            cflag(16'h0020, 16'h0020);
            line <= 2'h0;
        end
        $display("end resume test");
        // Bus reset fires once per episode
        wr(3'h1, 16'h00b5);
        line <= 2'h2;
        repeat (118) @(posedge ref_clk);
        cflag(16'h0001, 16'h0000);
        repeat (8) @(posedge ref_clk);
        cflag(16'h0001, 16'h0001);
        wr(3'h1, 16'h0001);
        repeat (130) @(posedge ref_clk);
        cflag(16'h0001, 16'h0000);
        line <= 2'h0;
        @(posedge ref_clk);
        line <= 2'h2;
        repeat (130) @(posedge ref_clk);
        cflag(16'h0001, 16'h0001);
        $display("end bus reset test");
        // Idle after the idle count
        line <= 2'h0;
        wr(3'h1, 16'h00b5);
        repeat (IDL - 10) @(posedge ref_clk);
        cflag(16'h0010, 16'h0000);
        repeat (10) @(posedge ref_clk);
        cflag(16'h0010, 16'h0010);
        $display("end idle test");
        // Error summary follows enabled error status only
        k = $urandom_range(7, 0);
        errs <= 8'h01 << k;
        @(posedge ref_clk);
        errs <= 8'h00;
        rc(3'h4, 16'h0001 << k);
        cflag(16'h0002, 16'h0000);
        wr(3'h3, 16'h0001 << k);
        cflag(16'h0002, 16'h0002);
        wr(3'h1, 16'h0002);
        cflag(16'h0002, 16'h0002);
        wr(3'h4, 16'h0001 << k);
        cflag(16'h0002, 16'h0000);
        $display("end error test");
        summarize();
    end
endmodule

// >>> verification/usf_bus_peer.sv
// Purpose: Peer model driving the USB data line states
// Assumes: Line code 0 J, 1 K, 2 single-ended zero, 3 J
// Notes: J and K swap with speed, so one code serves both
`timescale 1ns/100ps
module usf_bus_peer (
    input wire low_speed,
    input wire [1:0] line,
    output logic dp,
    output logic dm
);
    // K is differential 1 at low speed, 0 at full speed
    always_comb begin
        dp = (line == 2'h1) ~^ low_speed;
        dm = ~dp;
        if (line == 2'h2) begin
            dp = 1'h0;
            dm = 1'h0;
        end
    end
endmodule

// >>> verification/usf_flags_asserts.sv
// Purpose: Port assertions for the USB status and event flag block
// Assumes: Flag checks read the flag word one cycle after the event
// Notes: Line timers are left to the bench
`timescale 1ns/100ps
module usf_flags_chk #(
    parameter STABLE_CYC = 50000,
    parameter IDLE_CYC = 150000
) (
    input wire ref_clk,
    input wire rst_b,
    input wire [2:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata_reg,
    input wire irq,
    input wire cable_id_in,
    input wire sess_valid_in,
    input wire sess_end_in,
    input wire supply_valid_in,
    input wire stall_sent,
    input wire token_done,
    input wire sof_received,
    input wire sof_threshold,
    input wire token_ready
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    // Flag word read, and a stall clear with no stall racing it
    sequence rd_flags;
        reg_rd && reg_addr == 3'h1;
    endsequence
    sequence clr_stall;
        reg_wr && reg_addr == 3'h1 && reg_wdata[7] && !stall_sent;
    endsequence
    chk_upper_zero: assert property (reg_rdata_reg[15:8] == 8'h00)
        else $error("upper byte set");
    chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata_reg == 16'h0000)
        else $error("read data outside read cycle");
    chk_status_map: assert property ($past(rst_b, 2) && $past(reg_rd)
        && $past(reg_addr) == 3'h0 |-> reg_rdata_reg[7:0] == {$past(cable_id_in, 2), 1'b0,
        reg_rdata_reg[5], 1'b0, $past(sess_valid_in, 2), $past(sess_end_in, 2), 1'b0,
        $past(supply_valid_in, 2)}) else $error("status word wrong");
    chk_stall_flag: assert property (stall_sent ##1 rd_flags |=> reg_rdata_reg[7])
        else $error("stall flag not set");
    chk_token_flag: assert property (token_done ##1 rd_flags |=> reg_rdata_reg[3])
        else $error("token flag not set");
    chk_sof_flag: assert property ((sof_received || sof_threshold) ##1 rd_flags
        |=> reg_rdata_reg[2]) else $error("frame start flag not set");
    chk_w1c_clear: assert property (clr_stall ##1 rd_flags |=> !reg_rdata_reg[7])
        else $error("stall flag not cleared");
    chk_flag_sticky: assert property (rd_flags ##1 (rd_flags and reg_rdata_reg[7])
        |=> reg_rdata_reg[7]) else $error("flag lost without clear");
    chk_reset_state: assert property (!$past(rst_b) |-> token_ready && !irq)
        else $error("outputs not idle after reset");
endmodule

bind usf_flags usf_flags_chk #(.STABLE_CYC(STABLE_CYC), .IDLE_CYC(IDLE_CYC)) chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg), .irq(irq),
    .cable_id_in(cable_id_in), .sess_valid_in(sess_valid_in), .sess_end_in(sess_end_in),
    .supply_valid_in(supply_valid_in), .stall_sent(stall_sent), .token_done(token_done),
    .sof_received(sof_received), .sof_threshold(sof_threshold), .token_ready(token_ready));
